/* File: dv/pbt_buzzer_model.sv */
/* buzzer model: measures the pin period in clocks.
   assumes the pin is a plain level from the generator. */
`timescale 1ns/1ps
module pbt_buzzer_model (
   input wire logic clk,
   input wire logic pin,
   output int period
);
   // ------------------------------------------------------------
   // period between rising edges
   // ------------------------------------------------------------
   int cnt = 0;
   logic last = 1'b0;
   // clocks from one rising edge to the next
   always @(posedge clk) begin
      cnt <= cnt + 1;
      if (pin && !last) begin
         period <= cnt + 1;
         cnt <= 0;
      end
      last <= pin;
   end
endmodule

/* File: dv/pbt_checker.sv */
/* port checker of the tone generator.
   assumes it is bound to pbt_tone_gen, clk_en held high. */
`timescale 1ns/1ps
module pbt_checker #(parameter bit NEG_POLARITY = 1'b0)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tone_out_pin
);
   // ------------------------------------------------------------
   // shadow of control bits and pin run length
   // ------------------------------------------------------------
   logic en_reg, fq_reg, pin_reg;
   logic [7:0] quiet_reg, run_reg;
   wire ctl = paddr == 16'hff64;
   wire wr_done = psel && penable && pready && pwrite;
   // quiet counts clocks since the last write
   always_ff @(posedge clk) begin
      if (!rst_n || wr_done) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
      if (!rst_n) {fq_reg, en_reg} <= 2'h0;
      else if (wr_done && ctl) {fq_reg, en_reg} <= pwdata[1:0];
      pin_reg <= tone_out_pin;
      if (!rst_n || tone_out_pin != pin_reg) run_reg <= 8'h00;
      else if (run_reg != 8'hff) run_reg <= run_reg + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_access; psel && penable && !$past(penable); endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
   AST_WAIT_STATE: assert property (s_access |-> s_answer) else $error("pready not second");
   AST_SLVERR: assert property (pready |-> pslverr == !(ctl || paddr == 16'hff68))
      else $error("bad pslverr");
   AST_ERR_DATA: assert property (pready && pslverr |-> prdata == 32'h0) else $error("err data");
   AST_RD_ZERO: assert property (pready && !pwrite && ctl |-> prdata[31:2] == 30'h0)
      else $error("unused bits set");
   AST_RD_BACK: assert property (pready && !pwrite && ctl |-> prdata[1:0] == {fq_reg, en_reg})
      else $error("readback wrong");
   AST_IDLE: assert property (!en_reg && !$past(en_reg) |-> tone_out_pin == NEG_POLARITY)
      else $error("pin not idle");
   AST_HALF: assert property (en_reg && quiet_reg > 8'd40 && tone_out_pin != pin_reg
      |-> run_reg == (fq_reg ? 8'd15 : 8'd7)) else $error("half period wrong");
endmodule
bind pbt_tone_gen pbt_checker #(.NEG_POLARITY(NEG_POLARITY)) pbt_checker_inst (.clk, .rst_n,
   .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tone_out_pin);

/* File: dv/pbt_tone_gen_tb_top.sv */
/* testbench of the tone generator: apb tasks, register model, tone checks.
   assumes the checker binds itself. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("BAD %0t mismatch", $time); end end
module pbt_tone_gen_tb_top;
   // ------------------------------------------------------------
   // stimulus, model and verdict
   // ------------------------------------------------------------
   localparam bit NEG = 1'b1;
   localparam int TICK = 2; // clocks per oscillator tick at 125 MHz
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [15:0] paddr = 16'h0000, a;
   logic [31:0] pwdata = 32'h0, rd, seed = 32'h7a470ec4;
   logic [31:0] prdata;
   logic pready, pslverr, tone_out_pin;
   logic [1:0] m_ctrl = 2'h0;
   int fails = 0, compares = 0, period, cyc = 0;
   always #2 clk = ~clk;
   pbt_tone_gen #(.OSC_HZ(125000000), .NEG_POLARITY(NEG)) pbt_tone_gen_inst (.clk, .rst_n,
      .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .tone_out_pin);
   pbt_buzzer_model pbt_buzzer_model_inst (.clk, .pin(tone_out_pin), .period);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task give_verdict;
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         give_verdict;
      end
   end
   // one apb transfer, answer taken at the edge where pready is sampled high
   task bus(input logic w, input logic [15:0] ad, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // write, then read the control word back against the model
   task wr_chk(input logic [15:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d);
      if (ad == 16'hff64) m_ctrl = d[1:0];
      `CHK(err, ad != 16'hff64 && ad != 16'hff68)
      bus(1'b0, 16'hff64, 32'h0);
      `CHK(rd, {30'h0, m_ctrl})
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(tone_out_pin, NEG)
      bus(1'b0, 16'hff64, 32'h0);
      `CHK(rd, 32'h0)
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         a = (i % 3 == 0) ? 16'hff64 : (i % 3 == 1) ? 16'hff68 : (seed[15:0] | 16'h0001);
         wr_chk(a, seed);
      end
      for (int c = 1; c < 4; c += 2) begin
         wr_chk(16'hff64, 32'(c));
         repeat (100) @(posedge clk);
         `CHK(period, TICK * (c[1] ? 16 : 8))
      end
      wr_chk(16'hff64, 32'h0);
      repeat (3) @(negedge clk);
      `CHK(tone_out_pin, NEG)
      give_verdict;
   end
endmodule

/* File: rtl/pbt_defs.svh */
/*
 * constants of the piezo buzzer tone generator: register offsets, field
 * positions, reset values, clock rates and tone divide ratios.
 * assumes a 250 MHz system clock and a 16-bit APB byte address.
 */
//
// How it works
// - a set frequency-select bit gives a 2 kHz tone and a clear one gives 4 kHz.
// - the tone is the low-speed oscillator divided by 16/8, 32/16 or 64/32 by oscillator rate.
// - while the tone-enable bit is set the divided tone drives the buzzer pin.
// - with negative polarity the pin rests high while the tone-enable bit is clear.
// - with positive polarity the pin rests low while the tone-enable bit is clear.
// - the divider runs on regardless of enable, so switching may leave a short glitch.
// - the frequency-select bit is bit 1 of the control register at ff64.
// - the tone-enable bit is bit 0 of the control register at ff64.
// - control bits 3 and 2 read as zero and ignore writes.
// - reset clears both control bits, so the tone is off at 4 kHz.
// - both control bits read back the value last written.
`ifndef PBT_DEFS_SVH
`define PBT_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define PBT_ADDR_W 16
`define PBT_CTRL_OFF 16'hff64
`define PBT_STATUS_OFF 16'hff68
`define PBT_ENABLE_BIT 0
`define PBT_FREQ_BIT 1
`define PBT_CTRL_RESET 4'h0
`define PBT_PIN_BIT 0
`define PBT_TONE_BIT 1

// ---------------------------------------------------------------
// clock rates and tone ratios
// ---------------------------------------------------------------
`define PBT_CLK_PERIOD_NS 4
`define PBT_CLK_HZ (1000000000 / `PBT_CLK_PERIOD_NS)
`define PBT_OSC_32K_HZ 32768
`define PBT_OSC_76K_HZ 76800
`define PBT_OSC_153K_HZ 153600
`define PBT_RATIO_2K_32K 16
`define PBT_RATIO_2K_76K 32
`define PBT_RATIO_2K_153K 64

`endif

/* File: rtl/pbt_pkg.sv */
/*
 * types of the piezo buzzer tone generator.
 * assumes pbt_defs.svh is on the include path.
 */
`include "pbt_defs.svh"

package pbt_pkg;

   // ---------------------------------------------------------------
   // divider and top-level state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cnt;
      logic tone;
   } pbt_div_state_t;

   typedef struct packed {
      logic freq_sel;
      logic enable;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic pin;
      logic [31:0] acc;
      logic osc_tick;
   } pbt_state_t;

   // 2 kHz divide ratio for a given oscillator rate; 4 kHz is half of it
   function automatic logic [7:0] pbt_ratio_2k(input int unsigned osc_hz);
      logic [7:0] r;
      r = 8'(`PBT_RATIO_2K_32K);
      if (osc_hz == `PBT_OSC_76K_HZ) begin
         r = 8'(`PBT_RATIO_2K_76K);
      end else if (osc_hz == `PBT_OSC_153K_HZ) begin
         r = 8'(`PBT_RATIO_2K_153K);
      end
      return r;
   endfunction

endpackage

/* File: rtl/pbt_tone_div.sv */
/*
 * free-running tone divider: counts low-speed oscillator ticks and toggles
 * the tone every half period. assumes osc_tick is a one-cycle pulse.
 */
`timescale 1ns/1ps

module pbt_tone_div
   import pbt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic osc_tick,
   input wire logic [7:0] half_cnt,
   output logic tone
);

   pbt_div_state_t st_reg;
   pbt_div_state_t st_next;

   // count ticks; enable never touches this counter
   always_comb begin
      st_next = st_reg;
      if (osc_tick) begin
         if (st_reg.cnt >= half_cnt - 8'h01) begin
            st_next.cnt = 8'h00;
            st_next.tone = ~st_reg.tone;
         end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
         end
      end
   end

   // state register, frozen while clk_en is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign tone = st_reg.tone;

endmodule

/* File: rtl/pbt_tone_gen.sv */
/*
 * piezo buzzer tone generator top: APB slave with the control and status
 * registers, the low-speed oscillator tick, the divider and the pin driver.
 * assumes APB inputs are synchronous to clk and a single master.
 */
`timescale 1ns/1ps

module pbt_tone_gen
   import pbt_pkg::*;
#(
   parameter int unsigned OSC_HZ = `PBT_OSC_32K_HZ,
   parameter bit NEG_POLARITY = 1'b0
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tone_out_pin
);

   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam logic [32:0] CLK_HZ_W = 33'(`PBT_CLK_HZ);
   localparam logic [32:0] OSC_HZ_W = 33'(OSC_HZ);
   localparam logic [7:0] RATIO_2K = pbt_ratio_2k(OSC_HZ);
   localparam logic [7:0] HALF_2K = RATIO_2K >> 1;
   localparam logic [7:0] HALF_4K = RATIO_2K >> 2;
   localparam logic IDLE_LEVEL = NEG_POLARITY;
   localparam logic [3:0] CTRL_RESET = 4'(`PBT_CTRL_RESET);

   pbt_state_t st_reg;
   pbt_state_t st_next;
   logic tone;
   logic [7:0] half_cnt;
   logic [32:0] acc_sum;
   logic access;
   logic hit_ctrl;
   logic hit_status;

   // ---------------------------------------------------------------
   // tone divider
   // ---------------------------------------------------------------
   // 2 kHz when the select bit is set, 4 kHz when clear
   assign half_cnt = st_reg.freq_sel ? HALF_2K : HALF_4K;

   pbt_tone_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .osc_tick(st_reg.osc_tick),
      .half_cnt(half_cnt),
      .tone(tone)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign access = psel && penable;
   assign hit_ctrl = (paddr == `PBT_CTRL_OFF);
   assign hit_status = (paddr == `PBT_STATUS_OFF);
   assign acc_sum = {1'b0, st_reg.acc} + OSC_HZ_W;

   // next-state logic for bus, registers, oscillator tick and pin
   always_comb begin
      st_next = st_reg;
      // phase accumulator makes one tick per low-speed oscillator cycle
      if (acc_sum >= CLK_HZ_W) begin
         st_next.acc = 32'(acc_sum - CLK_HZ_W);
         st_next.osc_tick = 1'b1;
      end else begin
         st_next.acc = 32'(acc_sum);
         st_next.osc_tick = 1'b0;
      end
      // first access cycle: prepare answer, raise pready next cycle
      if (access && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.pslverr = ~(hit_ctrl | hit_status);
         st_next.prdata = 32'h0000_0000; // bits 3:2 and above read zero
         if (hit_ctrl) begin
            st_next.prdata[`PBT_ENABLE_BIT] = st_reg.enable;
            st_next.prdata[`PBT_FREQ_BIT] = st_reg.freq_sel;
         end else if (hit_status) begin
            st_next.prdata[`PBT_PIN_BIT] = st_reg.pin;
            st_next.prdata[`PBT_TONE_BIT] = tone;
         end
      end
      // completion edge: the write takes effect here and only here
      if (access && st_reg.pready) begin
         st_next.pready = 1'b0;
         st_next.pslverr = 1'b0;
         if (pwrite && hit_ctrl) begin
            // upper bits are dropped
            st_next.enable = pwdata[`PBT_ENABLE_BIT];
            st_next.freq_sel = pwdata[`PBT_FREQ_BIT];
         end
      end
      // gate the free tone onto the pin, idle level by polarity
      st_next.pin = st_reg.enable ? tone : IDLE_LEVEL; // ungated edges may glitch
   end

   // state register, frozen while clk_en is low; reset clears controls
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.enable <= CTRL_RESET[`PBT_ENABLE_BIT];
         st_reg.freq_sel <= CTRL_RESET[`PBT_FREQ_BIT];
         st_reg.pin <= IDLE_LEVEL;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign tone_out_pin = st_reg.pin;

endmodule
